// ---- rtl/piet_ctrl.sv ----
// prioritized interrupt controller with eight event transfer channels
// assumes cpu core and peripherals on the same clock; src_req and hw_trap are pulses
//
// Functional notes
// - per source choose vector or channel transfer
// - standard service vectors to source entry
// - one transfer steals exactly one cycle
// - transfer moves one byte or word
// - increment source or destination pointer, not both
// - count decrements unless continuous mode
// - zero count raises the source's vector
// - eight channels with own pointers, counter
// - per source request, enable, level register
// - sixteen levels arbitrate pending requests
// - preempt only for strictly higher level
// - every source has its own vector
// - software trap number selects vector
// - respond within 250 to 500 ns
// - hardware trap sets its trap flag bit
// - trap service blocks interrupts and transfers; software trap service keeps the running level and blocks neither
`timescale 1ns/1ps
module piet_ctrl #(
  parameter int STACK_DEPTH = 17
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // register port
  input wire logic [piet_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [piet_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [piet_pkg::DATA_W-1:0] reg_rdata,
  // request sources
  input wire logic [piet_pkg::NUM_SRC-1:0] src_req,
  input wire logic [piet_pkg::NUM_TRAP-1:0] hw_trap,
  // cpu side
  output logic vec_valid,
  output piet_pkg::piet_vec_t vec,
  input wire logic vec_ack,
  input wire logic svc_return,
  output logic xfer_valid,
  output piet_pkg::piet_xfer_t xfer,
  output logic [piet_pkg::LVL_W-1:0] cur_level,
  // interrupt
  output logic irq
);
  localparam int RESP_DLY = piet_pkg::RESP_MIN_CYC;

  // ==========================================================
  // declarations
  logic [piet_pkg::NUM_SRC-1:0] req_reg, en_reg, route_reg;
  // pending enabled sources sitting at the winning level, one bit each
  wire logic [piet_pkg::NUM_SRC-1:0] tie_vec;
  logic [3:0] lvl_reg [piet_pkg::NUM_SRC];
  logic [2:0] chsel_reg [piet_pkg::NUM_SRC];
  logic [piet_pkg::NUM_CH-1:0] word_reg, incdst_reg, cont_reg;
  logic [piet_pkg::CNT_W-1:0] count_reg [piet_pkg::NUM_CH];
  logic [piet_pkg::PTR_W-1:0] sptr_reg [piet_pkg::NUM_CH];
  logic [piet_pkg::PTR_W-1:0] dptr_reg [piet_pkg::NUM_CH];
  logic [piet_pkg::NUM_TRAP-1:0] trap_flags_reg, trap_pend_reg;
  logic swt_pend_reg;
  logic [6:0] swt_num_reg;
  logic [piet_pkg::ST_W-1:0] status_reg, mask_reg, status_ev;
  piet_pkg::piet_state_t st_reg;
  piet_pkg::piet_kind_t kind_reg;
  logic [4:0] wait_reg;
  logic [7:0] num_reg;
  logic [piet_pkg::LVL_W-1:0] svc_lvl_reg;
  logic [2:0] ch_reg;
  logic vec_valid_reg, xfer_valid_reg, irq_reg;
  piet_pkg::piet_vec_t vec_reg;
  piet_pkg::piet_xfer_t xfer_reg;
  logic [piet_pkg::DATA_W-1:0] rdata_reg, rd_next;
  logic best_found, trap_found, take_trap, take_sw, take_src, src_xfer, fire, ch_fire, push;
  logic [4:0] best_idx;
  logic [3:0] best_lvl;
  logic [2:0] trap_idx;
  logic src_hit, ch_hit;
  logic [2:0] best_ch;

  assign reg_rdata = rdata_reg;
  assign vec_valid = vec_valid_reg;
  assign vec = vec_reg;
  assign xfer_valid = xfer_valid_reg;
  assign xfer = xfer_reg;
  assign irq = irq_reg;
  assign src_hit = (reg_addr & 7'h60) == piet_pkg::ADR_SRC_BASE;
  assign ch_hit = (reg_addr & 7'h60) == piet_pkg::ADR_CH_BASE;

  // ==========================================================
  // arbitration
  always_comb begin
    best_found = 1'b0;
    best_idx = 5'h00;
    best_lvl = 4'h0;
    // walking down with >= leaves the lowest index on a tie
    for (int i = piet_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (req_reg[i] && en_reg[i] && {1'b0, lvl_reg[i]} > cur_level &&
          (!best_found || lvl_reg[i] >= best_lvl)) begin
        best_found = 1'b1;
        best_idx = 5'(i);
        best_lvl = lvl_reg[i];
      end
    end
    trap_found = 1'b0;
    trap_idx = 3'h0;
    for (int t = piet_pkg::NUM_TRAP - 1; t >= 0; t--) begin
      if (trap_pend_reg[t]) begin
        trap_found = 1'b1;
        trap_idx = 3'(t);
      end
    end
  end

  assign best_ch = chsel_reg[best_idx];
  assign take_trap = st_reg == piet_pkg::S_IDLE && trap_found && cur_level < piet_pkg::TRAP_LEVEL;
  assign take_sw = st_reg == piet_pkg::S_IDLE && !take_trap && swt_pend_reg;
  assign take_src = st_reg == piet_pkg::S_IDLE && !take_trap && !swt_pend_reg && best_found;
  // a routed source with an exhausted counter falls back to its vector
  assign src_xfer = route_reg[best_idx] && (count_reg[best_ch] != '0 || cont_reg[best_ch]);
  assign fire = st_reg == piet_pkg::S_WAIT && wait_reg == 5'h00;
  assign ch_fire = fire && kind_reg == piet_pkg::K_XFER;
  assign push = st_reg == piet_pkg::S_VEC && vec_ack;

  // ==========================================================
  // per source control
  for (genvar s = 0; s < piet_pkg::NUM_SRC; s++) begin : g_src
    logic hit;
    assign hit = reg_wr && src_hit && reg_addr[4:0] == 5'(s);
    assign tie_vec[s] = req_reg[s] && en_reg[s] && lvl_reg[s] == best_lvl;
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        req_reg[s] <= 1'b0;
      end else if (src_req[s]) begin
        req_reg[s] <= 1'b1;
      end else if (hit) begin
        req_reg[s] <= reg_wdata[piet_pkg::SC_REQ_BIT];
      end else if (take_src && best_idx == 5'(s)) begin
        req_reg[s] <= 1'b0;
      end
    end
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        en_reg[s] <= 1'b0;
        route_reg[s] <= 1'b0;
        lvl_reg[s] <= 4'h0;
        chsel_reg[s] <= 3'h0;
      end else if (hit) begin
        en_reg[s] <= reg_wdata[piet_pkg::SC_EN_BIT];
        route_reg[s] <= reg_wdata[piet_pkg::SC_ROUTE_BIT];
        lvl_reg[s] <= reg_wdata[piet_pkg::SC_LVL_LSB +: 4];
        chsel_reg[s] <= reg_wdata[piet_pkg::SC_CH_LSB +: 3];
      end
    end
  end

  // ==========================================================
  // transfer channels
  for (genvar c = 0; c < piet_pkg::NUM_CH; c++) begin : g_ch
    logic hit, go;
    logic [piet_pkg::PTR_W-1:0] step;
    assign hit = reg_wr && ch_hit && reg_addr[4:2] == 3'(c);
    assign go = ch_fire && ch_reg == 3'(c);
    assign step = word_reg[c] ? 16'h0002 : 16'h0001;
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        word_reg[c] <= 1'b0;
        incdst_reg[c] <= 1'b0;
        cont_reg[c] <= 1'b0;
      end else if (hit && reg_addr[1:0] == piet_pkg::CH_CTRL) begin
        word_reg[c] <= reg_wdata[piet_pkg::CC_WORD_BIT];
        incdst_reg[c] <= reg_wdata[piet_pkg::CC_INC_DST_BIT];
        cont_reg[c] <= reg_wdata[piet_pkg::CC_CONT_BIT];
      end
    end
    // the service's own update wins over a software write in the same cycle
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        count_reg[c] <= '0;
      end else if (go && !cont_reg[c]) begin
        count_reg[c] <= count_reg[c] - 1'b1;
      end else if (hit && reg_addr[1:0] == piet_pkg::CH_COUNT) begin
        count_reg[c] <= reg_wdata[piet_pkg::CNT_W-1:0];
      end
    end
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        sptr_reg[c] <= '0;
      end else if (go && !incdst_reg[c]) begin
        sptr_reg[c] <= sptr_reg[c] + step;
      end else if (hit && reg_addr[1:0] == piet_pkg::CH_SRC) begin
        sptr_reg[c] <= reg_wdata;
      end
    end
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        dptr_reg[c] <= '0;
      end else if (go && incdst_reg[c]) begin
        dptr_reg[c] <= dptr_reg[c] + step;
      end else if (hit && reg_addr[1:0] == piet_pkg::CH_DST) begin
        dptr_reg[c] <= reg_wdata;
      end
    end
    a_ptr_one_inc: assert property (@(posedge clock) disable iff (!resetn)
      go && !reg_wr |=> (sptr_reg[c] != $past(sptr_reg[c])) != (dptr_reg[c] != $past(dptr_reg[c])))
      else $error("not exactly one pointer moved");
    a_count_step: assert property (@(posedge clock) disable iff (!resetn)
      go && !reg_wr |=> count_reg[c] == ($past(cont_reg[c]) ? $past(count_reg[c]) : $past(count_reg[c]) - 8'h01))
      else $error("transfer count step wrong");
  end

  // ==========================================================
  // traps
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      trap_flags_reg <= '0;
    end else begin
      // a new trap wins over a write-one clear
      trap_flags_reg <= hw_trap | (trap_flags_reg & ~((reg_wr && reg_addr == piet_pkg::ADR_TRAP_FLAGS) ?
                        reg_wdata[piet_pkg::NUM_TRAP-1:0] : 8'h00));
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      trap_pend_reg <= '0;
    end else begin
      trap_pend_reg <= hw_trap | (trap_pend_reg & ~(take_trap ? 8'(1 << trap_idx) : 8'h00));
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      swt_pend_reg <= 1'b0;
      swt_num_reg <= 7'h00;
    end else if (reg_wr && reg_addr == piet_pkg::ADR_SW_TRAP) begin
      swt_pend_reg <= 1'b1;
      swt_num_reg <= reg_wdata[6:0];
    end else if (take_sw) begin
      swt_pend_reg <= 1'b0;
    end
  end

  // ==========================================================
  // service sequencer
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_reg <= piet_pkg::S_IDLE;
      kind_reg <= piet_pkg::K_SRC;
      wait_reg <= 5'h00;
      num_reg <= 8'h00;
      svc_lvl_reg <= piet_pkg::LEVEL_RST;
      ch_reg <= 3'h0;
    end else begin
      case (st_reg)
        piet_pkg::S_IDLE: begin
          wait_reg <= piet_pkg::WAIT_LOAD;
          if (take_trap) begin
            st_reg <= piet_pkg::S_WAIT;
            kind_reg <= piet_pkg::K_HW;
            num_reg <= piet_pkg::HW_TRAP_NUM[trap_idx];
            svc_lvl_reg <= piet_pkg::TRAP_LEVEL;
          end else if (take_sw) begin
            st_reg <= piet_pkg::S_WAIT;
            kind_reg <= piet_pkg::K_SW;
            num_reg <= {1'b0, swt_num_reg};
            svc_lvl_reg <= cur_level;
          end else if (take_src) begin
            st_reg <= piet_pkg::S_WAIT;
            kind_reg <= src_xfer ? piet_pkg::K_XFER : piet_pkg::K_SRC;
            num_reg <= piet_pkg::SRC_NUM_BASE + {3'h0, best_idx};
            svc_lvl_reg <= {1'b0, best_lvl};
            ch_reg <= best_ch;
          end
        end
        piet_pkg::S_WAIT: begin
          wait_reg <= wait_reg - 1'b1;
          if (fire) begin
            // a transfer needs no cpu answer; it is done in its one cycle
            st_reg <= (kind_reg == piet_pkg::K_XFER) ? piet_pkg::S_IDLE : piet_pkg::S_VEC;
          end
        end
        piet_pkg::S_VEC: begin
          if (vec_ack) begin
            st_reg <= piet_pkg::S_IDLE;
          end
        end
        default: st_reg <= piet_pkg::S_IDLE;
      endcase
    end
  end

  piet_level_stack #(.DEPTH(STACK_DEPTH), .W(piet_pkg::LVL_W)) u_stack (
    .clock(clock),
    .resetn(resetn),
    .push(push),
    .pop(svc_return),
    .push_val(svc_lvl_reg),
    .top(cur_level)
  );

  // ==========================================================
  // cpu outputs
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      vec_valid_reg <= 1'b0;
      vec_reg <= '0;
    end else if (fire && kind_reg != piet_pkg::K_XFER) begin
      vec_valid_reg <= 1'b1;
      vec_reg <= '{num: num_reg, addr: {num_reg, 2'b00}};
    end else if (push) begin
      vec_valid_reg <= 1'b0;
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      xfer_valid_reg <= 1'b0;
      xfer_reg <= '0;
    end else begin
      xfer_valid_reg <= ch_fire;
      if (ch_fire) begin
        xfer_reg <= '{src: sptr_reg[ch_reg], dst: dptr_reg[ch_reg], word: word_reg[ch_reg], ch: ch_reg};
      end
    end
  end

  // ==========================================================
  // status, mask, interrupt
  always_comb begin
    status_ev = '0;
    status_ev[piet_pkg::ST_TRAP] = take_trap;
    status_ev[piet_pkg::ST_VEC] = push;
    status_ev[piet_pkg::ST_CNT_ZERO] = take_src && route_reg[best_idx] && !src_xfer;
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status_reg <= '0;
      mask_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_ev | (status_reg & ~((reg_wr && reg_addr == piet_pkg::ADR_STATUS) ?
                    reg_wdata[piet_pkg::ST_W-1:0] : 3'h0));
      if (reg_wr && reg_addr == piet_pkg::ADR_MASK) begin
        mask_reg <= reg_wdata[piet_pkg::ST_W-1:0];
      end
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  // ==========================================================
  // register read
  always_comb begin
    rd_next = '0;
    if (src_hit) begin
      rd_next[piet_pkg::SC_REQ_BIT] = req_reg[reg_addr[4:0]];
      rd_next[piet_pkg::SC_EN_BIT] = en_reg[reg_addr[4:0]];
      rd_next[piet_pkg::SC_LVL_LSB +: 4] = lvl_reg[reg_addr[4:0]];
      rd_next[piet_pkg::SC_ROUTE_BIT] = route_reg[reg_addr[4:0]];
      rd_next[piet_pkg::SC_CH_LSB +: 3] = chsel_reg[reg_addr[4:0]];
    end else if (ch_hit) begin
      case (reg_addr[1:0])
        piet_pkg::CH_CTRL: begin
          rd_next[piet_pkg::CC_WORD_BIT] = word_reg[reg_addr[4:2]];
          rd_next[piet_pkg::CC_INC_DST_BIT] = incdst_reg[reg_addr[4:2]];
          rd_next[piet_pkg::CC_CONT_BIT] = cont_reg[reg_addr[4:2]];
        end
        piet_pkg::CH_COUNT: rd_next[piet_pkg::CNT_W-1:0] = count_reg[reg_addr[4:2]];
        piet_pkg::CH_SRC: rd_next = sptr_reg[reg_addr[4:2]];
        default: rd_next = dptr_reg[reg_addr[4:2]];
      endcase
    end else begin
      case (reg_addr)
        piet_pkg::ADR_TRAP_FLAGS: rd_next[piet_pkg::NUM_TRAP-1:0] = trap_flags_reg;
        piet_pkg::ADR_STATUS: rd_next[piet_pkg::ST_W-1:0] = status_reg;
        piet_pkg::ADR_MASK: rd_next[piet_pkg::ST_W-1:0] = mask_reg;
        piet_pkg::ADR_LEVEL: rd_next[piet_pkg::LVL_W-1:0] = cur_level;
        piet_pkg::ADR_SW_TRAP: rd_next[6:0] = swt_num_reg;
        default: rd_next = '0;
      endcase
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= reg_rd ? rd_next : 16'h0000;
    end
  end

  // ==========================================================
  // checks
  a_resp_time: assert property (@(posedge clock) disable iff (!resetn)
    take_src |-> ##RESP_DLY (vec_valid_reg || xfer_valid_reg))
    else $error("response not at minimum latency");
  a_xfer_single: assert property (@(posedge clock) disable iff (!resetn)
    xfer_valid_reg |=> !xfer_valid_reg && !vec_valid_reg)
    else $error("transfer took more than one cycle");
  a_req_cleared: assert property (@(posedge clock) disable iff (!resetn)
    take_src && !src_req[best_idx] && !(reg_wr && src_hit) |=> !req_reg[$past(best_idx)])
    else $error("accepted request flag not cleared");
  a_higher_only: assert property (@(posedge clock) disable iff (!resetn)
    take_src |-> {1'b0, best_lvl} > cur_level)
    else $error("taken request not above running level");
  a_trap_flag: assert property (@(posedge clock) disable iff (!resetn)
    |hw_trap |=> (trap_flags_reg & $past(hw_trap)) == $past(hw_trap) && (trap_pend_reg & $past(hw_trap)) == $past(hw_trap))
    else $error("trap flag not set");
  a_trap_blocks: assert property (@(posedge clock) disable iff (!resetn)
    cur_level == piet_pkg::TRAP_LEVEL |-> !take_src)
    else $error("request taken during trap service");
  a_zero_vector: assert property (@(posedge clock) disable iff (!resetn)
    take_src && !src_xfer |-> ##RESP_DLY vec_valid_reg && vec_reg.num == piet_pkg::SRC_NUM_BASE + {3'h0, $past(best_idx, RESP_DLY)})
    else $error("source vector wrong");
  a_tie_lowest: assert property (@(posedge clock) disable iff (!resetn)
    take_src |-> (tie_vec & ((32'h00000001 << best_idx) - 32'h00000001)) == 32'h00000000)
    else $error("tie not given to lowest source");
endmodule

// ---- rtl/piet_level_stack.sv ----
// stack of interrupted priority levels, top is the running level
// assumes push and pop come from the same clock domain
`timescale 1ns/1ps
module piet_level_stack #(
  parameter int DEPTH = 17,
  parameter int W = 5
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // control
  input wire logic push,
  input wire logic pop,
  input wire logic [W-1:0] push_val,
  output logic [W-1:0] top
);
  localparam int PW = $clog2(DEPTH + 1);
  logic [W-1:0] mem_reg [DEPTH];
  logic [PW-1:0] ptr_reg;
  logic [W-1:0] top_reg;

  assign top = top_reg;

  // ==========================================================
  // storage
  // a push into a full stack still takes the new level; the oldest is kept
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      ptr_reg <= '0;
      top_reg <= '0;
    end else if (push) begin
      top_reg <= push_val;
      if (ptr_reg != PW'(DEPTH)) begin
        mem_reg[ptr_reg] <= top_reg;
        ptr_reg <= ptr_reg + 1'b1;
      end
    end else if (pop && ptr_reg != '0) begin
      top_reg <= mem_reg[ptr_reg - 1'b1];
      ptr_reg <= ptr_reg - 1'b1;
    end
  end
endmodule

// ---- rtl/piet_pkg.sv ----
// constants and carrier types for the interrupt and event transfer block
// assumes a single 40 MHz clock domain shared with the cpu core
package piet_pkg;
  // ==========================================================
  // sizes
  localparam int NUM_SRC = 32;
  localparam int NUM_CH = 8;
  localparam int NUM_TRAP = 8;
  localparam int LVL_W = 5;
  localparam int PTR_W = 16;
  localparam int CNT_W = 8;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 7;
  // ==========================================================
  // register indices
  localparam logic [6:0] ADR_SRC_BASE = 7'h00;
  localparam logic [6:0] ADR_CH_BASE = 7'h20;
  localparam logic [6:0] ADR_TRAP_FLAGS = 7'h40;
  localparam logic [6:0] ADR_STATUS = 7'h41;
  localparam logic [6:0] ADR_MASK = 7'h42;
  localparam logic [6:0] ADR_LEVEL = 7'h43;
  localparam logic [6:0] ADR_SW_TRAP = 7'h44;
  localparam logic [1:0] CH_CTRL = 2'h0;
  localparam logic [1:0] CH_COUNT = 2'h1;
  localparam logic [1:0] CH_SRC = 2'h2;
  localparam logic [1:0] CH_DST = 2'h3;
  // ==========================================================
  // field positions
  localparam int SC_CH_LSB = 0;
  localparam int SC_ROUTE_BIT = 3;
  localparam int SC_LVL_LSB = 4;
  localparam int SC_EN_BIT = 8;
  localparam int SC_REQ_BIT = 9;
  localparam int CC_WORD_BIT = 0;
  localparam int CC_INC_DST_BIT = 1;
  localparam int CC_CONT_BIT = 2;
  localparam int ST_TRAP = 0;
  localparam int ST_VEC = 1;
  localparam int ST_CNT_ZERO = 2;
  localparam int ST_W = 3;
  // ==========================================================
  // reset values and numbers
  localparam logic [4:0] LEVEL_RST = 5'h00;
  localparam logic [4:0] TRAP_LEVEL = 5'h10;
  localparam logic [7:0] SRC_NUM_BASE = 8'h10;
  // bit 0 nmi, 1 stack overflow, 2 stack underflow, 3..7 class b
  localparam logic [7:0][7:0] HW_TRAP_NUM = {8'h0A, 8'h0A, 8'h0A, 8'h0A, 8'h0A, 8'h06, 8'h04, 8'h02};
  // ==========================================================
  // timing
  localparam int CLK_NS = 25;
  localparam int RESP_MIN_NS = 250;
  localparam int RESP_MAX_NS = 500;
  localparam int RESP_MIN_CYC = (RESP_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESP_MAX_CYC = RESP_MAX_NS / CLK_NS;
  localparam logic [4:0] WAIT_LOAD = 5'(RESP_MIN_CYC - 2);
  // ==========================================================
  // types
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_VEC} piet_state_t;
  typedef enum logic [1:0] {K_HW, K_SW, K_SRC, K_XFER} piet_kind_t;
  typedef struct packed {
    logic [7:0] num;
    logic [9:0] addr;
  } piet_vec_t;
  typedef struct packed {
    logic [PTR_W-1:0] src;
    logic [PTR_W-1:0] dst;
    logic word;
    logic [2:0] ch;
  } piet_xfer_t;
endpackage

// ---- tb/piet_cpu_model.sv ----
// cpu core stand-in: takes vectors offered by the controller
// assumes one clock shared with the controller; dly sets ack speed
`timescale 1ns/1ps
module piet_cpu_model (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // vector handshake
  input wire logic vec_valid,
  input wire logic [3:0] dly,
  output logic vec_ack
);
  logic [3:0] wait_reg;
  // ==========================================================
  // acknowledge
  // one pulse per offered vector; never acks twice in one offer
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wait_reg <= 4'h0;
      vec_ack <= 1'b0;
    end else begin
      vec_ack <= 1'b0;
      if (vec_valid && !vec_ack) begin
        if (wait_reg == dly) begin
          vec_ack <= 1'b1;
          wait_reg <= 4'h0;
        end else begin
          wait_reg <= wait_reg + 4'h1;
        end
      end
    end
  end
endmodule

// ---- tb/piet_ctrl_tb.sv ----
// self-checking bench for the interrupt and transfer controller
// assumes the cpu model acks vectors; bench drives registers and requests
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module piet_ctrl_tb;
  logic clock, resetn, reg_wr, reg_rd, vec_ack, svc_return, vec_valid, xfer_valid, irq;
  logic [6:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [31:0] src_req;
  logic [7:0] hw_trap;
  logic [3:0] dly;
  logic [4:0] cur_level;
  piet_pkg::piet_vec_t vec;
  piet_pkg::piet_xfer_t xfer;
  int err_total, checks_done, cyc, n;
  logic [15:0] cc[3] = '{16'h0001, 16'h0006, 16'h0000};
  logic [15:0] xs[3] = '{16'h0100, 16'h0102, 16'h0102};
  logic [15:0] xd[3] = '{16'h0200, 16'h0200, 16'h0201};
  logic [15:0] cn[3] = '{16'h0001, 16'h0001, 16'h0000};
  piet_ctrl piet_ctrl_inst (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req), .hw_trap(hw_trap),
    .vec_valid(vec_valid), .vec(vec), .vec_ack(vec_ack), .svc_return(svc_return),
    .xfer_valid(xfer_valid), .xfer(xfer), .cur_level(cur_level), .irq(irq));
  piet_cpu_model piet_cpu_model_inst (.clock(clock), .resetn(resetn), .vec_valid(vec_valid),
    .dly(dly), .vec_ack(vec_ack));
  always #12.5 clock = ~clock;
  // ==========================================================
  // tasks
  task conclude;
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  task wr(input logic [6:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [6:0] a);
    @(posedge clock);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // pulse requests, then count edges until a vector or transfer shows (40 = none)
  task req(input logic [31:0] m, input logic [7:0] t);
    @(posedge clock);
    src_req <= m; hw_trap <= t; n = 0;
    do begin
      @(posedge clock);
      src_req <= '0; hw_trap <= '0; n++;
      #1;
    end while (!(vec_valid | xfer_valid) && n < 40);
  endtask
  task ret;
    @(posedge clock);
    svc_return <= 1'b1;
    @(posedge clock);
    svc_return <= 1'b0;
  endtask
  // ==========================================================
  // sequence
  initial begin
    clock = 0; resetn = 0; reg_addr = '0; reg_wdata = '0; reg_wr = 0; reg_rd = 0; src_req = '0;
    hw_trap = '0; svc_return = 0; dly = 4'h0; err_total = 0; checks_done = 0; cyc = 0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    rd(7'h43); `CHK("level", 16'h0000, d)
    wr(7'h03, 16'h0150);
    req(32'h8, '0); `CHK("resp", 11, n)
    `CHK("vec", {8'h13, 10'h04C}, vec)
    rd(7'h03); `CHK("srcctl", 16'h0150, d)
    rd(7'h43); `CHK("level", 16'h0005, d)
    `CHK("curlvl", 5'h05, cur_level)
    wr(7'h04, 16'h0150);
    req(32'h10, '0); `CHK("same", 40, n)
    wr(7'h06, 16'h0170);
    req(32'h40, '0); `CHK("vec", {8'h16, 10'h058}, vec)
    wr(7'h04, 16'h0150);
    ret(); ret(); rd(7'h43); `CHK("level", 16'h0000, d)
    wr(7'h09, 16'h0120); wr(7'h0A, 16'h0120);
    req(32'h600, '0); `CHK("tie", 8'h19, vec.num)
    repeat (4) @(posedge clock);
    ret(); repeat (20) @(posedge clock); ret();
    rd(7'h43); `CHK("level", 16'h0000, d)
    // transfers: word/src step, byte/dst step continuous, byte/src step
    wr(7'h08, 16'h013A); wr(7'h29, 16'h0002); wr(7'h2A, 16'h0100); wr(7'h2B, 16'h0200);
    for (int i = 0; i < 3; i++) begin
      wr(7'h28, cc[i]);
      req(32'h100, '0); `CHK("resp", 11, n)
      `CHK("xfer", {xs[i], xd[i], cc[i][0], 3'h2}, xfer)
      @(posedge clock); #1 `CHK("onecyc", 1'b0, xfer_valid)
      rd(7'h29); `CHK("count", cn[i], d)
    end
    rd(7'h2A); `CHK("srcptr", 16'h0103, d)
    req(32'h100, '0); `CHK("vec", {8'h18, 10'h060}, vec)
    repeat (4) @(posedge clock); ret();
    rd(7'h41); `CHK("zero", 1'b1, d[2])
    wr(7'h44, 16'h0025);
    req('0, '0); `CHK("swtrap", {8'h25, 10'h094}, vec)
    repeat (4) @(posedge clock); ret();
    dly <= 4'h4;
    req('0, 8'h02); `CHK("trap", {8'h04, 10'h010}, vec)
    repeat (3) @(posedge clock); #1 `CHK("hold", 1'b1, vec_valid)
    repeat (8) @(posedge clock);
    rd(7'h40); `CHK("tflag", 16'h0002, d)
    rd(7'h43); `CHK("level", 16'h0010, d)
    `CHK("curlvl", 5'h10, cur_level)
    req(32'h8, '0); `CHK("blocked", 40, n)
    wr(7'h03, 16'h0150); ret();
    wr(7'h42, 16'h0002); repeat (2) @(posedge clock); #1 `CHK("irq", 1'b1, irq)
    wr(7'h41, 16'h0007); repeat (2) @(posedge clock); #1 `CHK("irq", 1'b0, irq)
    rd(7'h50); `CHK("unmapped", 16'h0000, d)
    conclude();
  end
endmodule
